// ---- verilog/spbs_pkg.sv ----
/*
  Shared constants and parity helper for the secondary bus link.
  Assumes both ends, the assertions and the bench refer to it by package::name.
*/
`default_nettype none
package spbs_pkg;
  // Bus commands used by the initiator
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  // Clocks a target has to claim a cycle after the frame starts
  localparam logic [2:0] DEVSEL_WAIT = 3'h5;
  localparam logic [2:0] DEVSEL_LAST = DEVSEL_WAIT - 3'h1;
  // Fast clock status bit inside the status/command word
  localparam int STATUS_FAST_BIT = 21;
  // Strap vector layout
  localparam int STRAP_SYNC = 0;
  localparam int STRAP_P66 = 1;
  localparam int STRAP_CFG = 2;
  // Reset values of the driven lanes
  localparam logic [31:0] AD_RST = 32'h0000_0000;
  localparam logic [3:0] CBE_RST = 4'h0;

  // Even parity: value for the parity line over address/data and command lanes
  function automatic logic spbs_even_par(input logic [31:0] ad, input logic [3:0] cbe);
    return ^{ad, cbe};
  endfunction : spbs_even_par
endpackage : spbs_pkg
`default_nettype wire

// ---- verilog/spbs_bus_if.sv ----
/*
  Carrier for the secondary bus: each party's drive and enable, and the resolved lines.
  Assumes the bench supplies the link clock; undriven lines float to the pulled-up level.
*/
`timescale 1ns/10ps
`default_nettype none
interface spbs_bus_if (input wire logic pci_clk);
  logic [31:0] dev_ad;
  logic dev_ad_oe;
  logic [3:0] dev_cbe;
  logic dev_cbe_oe;
  logic dev_par;
  logic dev_par_oe;
  logic dev_frame_n;
  logic dev_frame_oe;
  logic dev_irdy_n;
  logic dev_irdy_oe;
  logic dev_m66_oe;
  logic dev_sec_rst_n;
  logic [31:0] far_ad;
  logic far_ad_oe;
  logic far_par;
  logic far_par_oe;
  logic far_trdy_n;
  logic far_trdy_oe;
  logic far_devsel_n;
  logic far_devsel_oe;
  logic far_m66_oe;
  logic far_gnt_n;
  // Resolved lines
  logic [31:0] ad;
  logic [3:0] cbe;
  logic par;
  logic frame_n;
  logic secondary_initiator_ready_n;
  logic secondary_target_ready_n;
  logic secondary_device_select_n;
  logic secondary_fast_clock_capable_line;

  assign ad = dev_ad_oe ? dev_ad : (far_ad_oe ? far_ad : 32'hffff_ffff);
  assign cbe = dev_cbe_oe ? dev_cbe : 4'hf;
  assign par = dev_par_oe ? dev_par : (far_par_oe ? far_par : 1'b1);
  assign frame_n = dev_frame_oe ? dev_frame_n : 1'b1;
  assign secondary_initiator_ready_n = dev_irdy_oe ? dev_irdy_n : 1'b1;
  assign secondary_target_ready_n = far_trdy_oe ? far_trdy_n : 1'b1;
  assign secondary_device_select_n = far_devsel_oe ? far_devsel_n : 1'b1;
  assign secondary_fast_clock_capable_line = ~(dev_m66_oe | far_m66_oe);

  modport dev (
    input pci_clk, ad, cbe, par, frame_n, secondary_initiator_ready_n, secondary_target_ready_n,
    input secondary_device_select_n, far_gnt_n,
    output dev_ad, dev_ad_oe, dev_cbe, dev_cbe_oe, dev_par, dev_par_oe, dev_frame_n, dev_frame_oe,
    output dev_irdy_n, dev_irdy_oe, dev_m66_oe, dev_sec_rst_n
  );
  modport far (
    input pci_clk, ad, cbe, par, frame_n, secondary_initiator_ready_n, dev_sec_rst_n,
    input secondary_fast_clock_capable_line,
    output far_ad, far_ad_oe, far_par, far_par_oe, far_trdy_n, far_trdy_oe,
    output far_devsel_n, far_devsel_oe, far_m66_oe, far_gnt_n
  );
endinterface : spbs_bus_if
`default_nettype wire

// ---- verilog/spbs_bridge_end.sv ----
/*
  Bridge end of the secondary bus: single-word initiator, parking, reset drive,
  fast clock strap handling. User side on i_ref_clk, bus side on the link clock.
  Assumes the far party arbitrates (grant line) and acts as target.
*/
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Sync mode, slow primary pulls secondary low
// - Async mode, status bit follows primary level
// - Data moves only when both readies low
// - Frame start carries address on lanes
// - Idle with grant: park lanes and parity
// - Command in address phase, enables after
// - Parity makes lanes plus parity even
// - Parity lags its lanes by one clock
// - Parity released a clock after lanes
// - Frame high marks the final data phase
// - Drive control high one clock before release
// - Asserted ready held until phase completes
// - No claim within five clocks: master abort
// - Secondary reset: controls off, lanes zero
module spbs_bridge_end (
  // User clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Request
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [31:0] i_req_addr,
  input wire logic [31:0] i_req_data,
  input wire logic [3:0] i_req_be,
  output logic o_req_ready,
  // Answer
  output logic o_rsp_valid,
  output logic [31:0] o_rsp_data,
  output logic o_rsp_abort,
  // Straps and control
  input wire logic i_sync_mode,
  input wire logic i_primary_fast_clock_capable_in,
  input wire logic i_fast_clock_config_strap,
  input wire logic i_sec_bus_reset,
  output logic [31:0] o_status_word,
  // Bus
  spbs_bus_if.dev bus
);
  typedef enum logic [1:0] {L_IDLE = 2'h0, L_ADDR = 2'h1, L_DATA = 2'h3, L_TURN = 2'h2} spbs_lst_t;

  wire logic lclk = bus.pci_clk;

  // User domain
  logic req_tgl, next_req_tgl, next_req_ready;
  logic req_write, next_req_write;
  logic [31:0] req_addr, next_req_addr, req_data, next_req_data;
  logic [3:0] req_be, next_req_be;
  logic done_s1, done_s2, done_seen, next_done_seen;
  logic next_rsp_valid, next_rsp_abort;
  logic [31:0] next_rsp_data, next_status;
  logic [2:0] strap_s1, strap_s2;
  logic m66_oe, next_m66_oe;
  // Link domain results, stable while their toggle is unanswered
  logic done_tgl, l_abort;
  logic [31:0] l_rdata;

  always_comb
  begin
    next_req_tgl = req_tgl;
    next_req_ready = o_req_ready;
    next_req_write = req_write;
    next_req_addr = req_addr;
    next_req_data = req_data;
    next_req_be = req_be;
    next_done_seen = done_seen;
    next_rsp_valid = 1'b0;
    next_rsp_data = o_rsp_data;
    next_rsp_abort = o_rsp_abort;
    if (i_req_valid && o_req_ready)
    begin
      next_req_write = i_req_write;
      next_req_addr = i_req_addr;
      next_req_data = i_req_data;
      next_req_be = i_req_be;
      next_req_tgl = ~req_tgl;
      next_req_ready = 1'b0;
    end
    if (done_s2 != done_seen)
    begin
      next_done_seen = done_s2;
      next_rsp_valid = 1'b1;
      next_rsp_data = l_rdata;
      next_rsp_abort = l_abort;
      next_req_ready = 1'b1;
    end
    next_m66_oe = strap_s2[spbs_pkg::STRAP_SYNC] & ~strap_s2[spbs_pkg::STRAP_P66];
    next_status = 32'h0000_0000;
    next_status[spbs_pkg::STATUS_FAST_BIT] = strap_s2[spbs_pkg::STRAP_SYNC] ?
      strap_s2[spbs_pkg::STRAP_CFG] : strap_s2[spbs_pkg::STRAP_P66];
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      req_tgl <= 1'b0;
      o_req_ready <= 1'b1;
      req_write <= 1'b0;
      req_addr <= 32'h0000_0000;
      req_data <= 32'h0000_0000;
      req_be <= 4'h0;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_seen <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_data <= 32'h0000_0000;
      o_rsp_abort <= 1'b0;
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
      m66_oe <= 1'b0;
      o_status_word <= 32'h0000_0000;
    end
    else
    begin
      req_tgl <= next_req_tgl;
      o_req_ready <= next_req_ready;
      req_write <= next_req_write;
      req_addr <= next_req_addr;
      req_data <= next_req_data;
      req_be <= next_req_be;
      done_s1 <= done_tgl;
      done_s2 <= done_s1;
      done_seen <= next_done_seen;
      o_rsp_valid <= next_rsp_valid;
      o_rsp_data <= next_rsp_data;
      o_rsp_abort <= next_rsp_abort;
      strap_s1 <= {i_fast_clock_config_strap, i_primary_fast_clock_capable_in, i_sync_mode};
      strap_s2 <= strap_s1;
      m66_oe <= next_m66_oe;
      o_status_word <= next_status;
    end
  end

  assign bus.dev_m66_oe = m66_oe;

  // Link domain
  logic lrst_s1, lrst_s2, srst_s1, srst_s2, req_s1, req_s2;
  logic sec_rst;
  spbs_lst_t lst, next_lst;
  logic [2:0] wait_cnt, next_wait_cnt;
  logic req_seen, next_req_seen, next_done_tgl, next_l_abort;
  logic [31:0] next_l_rdata, ad_o, next_ad_o;
  logic [3:0] cbe_o, next_cbe_o;
  logic ad_oe, next_ad_oe, cbe_oe, next_cbe_oe, par_o, next_par_o, par_oe, next_par_oe;
  logic frame_o, next_frame_o, frame_oe, next_frame_oe;
  logic irdy_o, next_irdy_o, irdy_oe, next_irdy_oe, rst_n_o;
  logic bus_idle;

  // Either the system reset or the user's bus reset holds the secondary bus
  assign sec_rst = lrst_s2 | srst_s2;
  assign bus_idle = bus.frame_n & bus.secondary_initiator_ready_n;

  always_comb
  begin
    next_lst = lst;
    next_wait_cnt = wait_cnt;
    next_req_seen = req_seen;
    next_done_tgl = done_tgl;
    next_l_abort = l_abort;
    next_l_rdata = l_rdata;
    next_ad_o = ad_o;
    next_ad_oe = ad_oe;
    next_cbe_o = cbe_o;
    next_cbe_oe = cbe_oe;
    next_frame_o = frame_o;
    next_frame_oe = frame_oe;
    next_irdy_o = irdy_o;
    next_irdy_oe = irdy_oe;
    // even parity over what is on the lanes now
    next_par_o = spbs_pkg::spbs_even_par(bus.ad, bus.cbe);
    // parity follows lane drive by one clock
    // parity released a clock after the lanes
    next_par_oe = ad_oe;
    unique case (lst)
      L_IDLE:
      begin
        // ready was driven high last clock, frame the clock before that
        next_frame_oe = 1'b0;
        next_irdy_oe = 1'b0;
        next_ad_oe = 1'b0;
        next_cbe_oe = 1'b0;
        if (!bus.far_gnt_n && bus_idle)
        begin
          if (req_s2 != req_seen)
          begin
            // frame low with address on the lanes
            next_req_seen = req_s2;
            next_lst = L_ADDR;
            next_wait_cnt = 3'h0;
            next_frame_o = 1'b0;
            next_frame_oe = 1'b1;
            next_irdy_o = 1'b1;
            next_irdy_oe = 1'b1;
            next_ad_o = req_addr;
            next_ad_oe = 1'b1;
            next_cbe_o = req_write ? spbs_pkg::CMD_MEM_WR : spbs_pkg::CMD_MEM_RD;
            next_cbe_oe = 1'b1;
          end
          else
          begin
            // park lanes while idle and granted
            next_ad_o = spbs_pkg::AD_RST;
            next_ad_oe = 1'b1;
            next_cbe_o = spbs_pkg::CBE_RST;
            next_cbe_oe = 1'b1;
          end
        end
      end
      L_ADDR:
      begin
        // single word, so the first data phase is the last
        next_frame_o = 1'b1;
        next_irdy_o = 1'b0;
        next_ad_o = req_data;
        next_ad_oe = req_write;
        // byte enables in the data phase
        next_cbe_o = req_be;
        next_wait_cnt = 3'h1;
        next_lst = L_DATA;
      end
      L_DATA:
      begin
        if (wait_cnt != spbs_pkg::DEVSEL_WAIT)
          next_wait_cnt = wait_cnt + 3'h1;
        if (!bus.secondary_initiator_ready_n && !bus.secondary_target_ready_n)
        begin
          next_l_rdata = bus.ad;
          next_l_abort = 1'b0;
          next_done_tgl = ~done_tgl;
          next_lst = L_TURN;
        end
        // nobody claimed by the fifth clock
        else if (bus.secondary_device_select_n && wait_cnt == spbs_pkg::DEVSEL_LAST)
        begin
          next_l_rdata = 32'hffff_ffff;
          next_l_abort = 1'b1;
          next_done_tgl = ~done_tgl;
          next_lst = L_TURN;
        end
        // ready stays low until one of the above
        if (next_lst == L_TURN)
        begin
          // ready driven high for one clock first
          next_irdy_o = 1'b1;
          next_frame_oe = 1'b0;
          next_ad_oe = 1'b0;
          next_cbe_oe = 1'b0;
        end
      end
      L_TURN:
      begin
        // ready released after its one high clock
        next_irdy_oe = 1'b0;
        next_lst = L_IDLE;
      end
    endcase
    // reset holds controls off and zeros on the lanes
    if (sec_rst)
    begin
      next_lst = L_IDLE;
      // A request pending through reset is served afterwards, not lost
      next_req_seen = req_seen;
      next_ad_o = spbs_pkg::AD_RST;
      next_ad_oe = 1'b1;
      next_cbe_o = spbs_pkg::CBE_RST;
      next_cbe_oe = 1'b1;
      next_par_o = 1'b0;
      next_par_oe = 1'b1;
      next_frame_oe = 1'b0;
      next_irdy_oe = 1'b0;
    end
  end

  always_ff @(posedge lclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      lrst_s1 <= 1'b1;
      lrst_s2 <= 1'b1;
      srst_s1 <= 1'b0;
      srst_s2 <= 1'b0;
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      lst <= L_IDLE;
      wait_cnt <= 3'h0;
      req_seen <= 1'b0;
      done_tgl <= 1'b0;
      l_abort <= 1'b0;
      l_rdata <= 32'h0000_0000;
      ad_o <= spbs_pkg::AD_RST;
      ad_oe <= 1'b1;
      cbe_o <= spbs_pkg::CBE_RST;
      cbe_oe <= 1'b1;
      par_o <= 1'b0;
      par_oe <= 1'b1;
      frame_o <= 1'b1;
      frame_oe <= 1'b0;
      irdy_o <= 1'b1;
      irdy_oe <= 1'b0;
      rst_n_o <= 1'b0;
    end
    else
    begin
      lrst_s1 <= 1'b0;
      lrst_s2 <= lrst_s1;
      srst_s1 <= i_sec_bus_reset;
      srst_s2 <= srst_s1;
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      lst <= next_lst;
      wait_cnt <= next_wait_cnt;
      req_seen <= next_req_seen;
      done_tgl <= next_done_tgl;
      l_abort <= next_l_abort;
      l_rdata <= next_l_rdata;
      ad_o <= next_ad_o;
      ad_oe <= next_ad_oe;
      cbe_o <= next_cbe_o;
      cbe_oe <= next_cbe_oe;
      par_o <= next_par_o;
      par_oe <= next_par_oe;
      frame_o <= next_frame_o;
      frame_oe <= next_frame_oe;
      irdy_o <= next_irdy_o;
      irdy_oe <= next_irdy_oe;
      rst_n_o <= ~sec_rst;
    end
  end

  assign bus.dev_ad = ad_o;
  assign bus.dev_ad_oe = ad_oe;
  assign bus.dev_cbe = cbe_o;
  assign bus.dev_cbe_oe = cbe_oe;
  assign bus.dev_par = par_o;
  assign bus.dev_par_oe = par_oe;
  assign bus.dev_frame_n = frame_o;
  assign bus.dev_frame_oe = frame_oe;
  assign bus.dev_irdy_n = irdy_o;
  assign bus.dev_irdy_oe = irdy_oe;
  assign bus.dev_sec_rst_n = rst_n_o;
endmodule : spbs_bridge_end
`default_nettype wire

// ---- verilog/spbs_agent_end.sv ----
/*
  Far party on the secondary bus: grant source, single-word memory target,
  parity checker. Runs wholly on the link clock.
  Assumes the bridge end is the only initiator.
*/
`timescale 1ns/10ps
`default_nettype none
module spbs_agent_end (
  // Reset
  input wire logic i_sys_rst,
  // Control, on the link clock
  input wire logic i_grant_device,
  input wire logic i_target_enable,
  input wire logic i_slow_bus,
  input wire logic [31:0] i_read_data,
  // Results
  output logic o_wr_valid,
  output logic [31:0] o_wr_addr,
  output logic [31:0] o_wr_data,
  output logic [3:0] o_wr_be,
  output logic o_par_err,
  output logic o_fast_capable,
  // Bus
  spbs_bus_if.far bus
);
  typedef enum logic [1:0] {T_IDLE = 2'h0, T_CLAIM = 2'h1, T_DATA = 2'h3, T_TURN = 2'h2} spbs_tst_t;

  spbs_tst_t tst, next_tst;
  logic write_q, next_write_q, frame_prev;
  logic [31:0] next_wr_addr, next_wr_data, ad_o, next_ad_o;
  logic [3:0] next_wr_be;
  logic next_wr_valid, ad_oe, next_ad_oe, par_o, next_par_o, par_oe;
  logic trdy_o, next_trdy_o, trdy_oe, next_trdy_oe;
  logic devsel_o, next_devsel_o, devsel_oe, next_devsel_oe;
  logic chk_en, next_chk_en, next_par_err;
  logic [35:0] chk_lanes, next_chk_lanes;
  logic gnt_n, m66_oe, m66_s1;
  logic bus_rst;

  assign bus_rst = ~bus.dev_sec_rst_n;

  always_comb
  begin
    next_tst = tst;
    next_write_q = write_q;
    next_wr_addr = o_wr_addr;
    next_wr_data = o_wr_data;
    next_wr_be = o_wr_be;
    next_wr_valid = 1'b0;
    next_ad_o = ad_o;
    next_ad_oe = ad_oe;
    next_trdy_o = trdy_o;
    next_trdy_oe = trdy_oe;
    next_devsel_o = devsel_o;
    next_devsel_oe = devsel_oe;
    next_chk_en = 1'b0;
    next_chk_lanes = {bus.cbe, bus.ad};
    // read data parity covers our lanes and the enables
    next_par_o = spbs_pkg::spbs_even_par(bus.ad, bus.cbe);
    // a mismatch a clock after the covered lanes
    next_par_err = chk_en && (spbs_pkg::spbs_even_par(chk_lanes[31:0], chk_lanes[35:32]) != bus.par);
    unique case (tst)
      T_IDLE:
      begin
        next_trdy_oe = 1'b0;
        next_devsel_oe = 1'b0;
        // address taken on the first low frame clock
        if (frame_prev && !bus.frame_n)
        begin
          next_chk_en = 1'b1;
          if (i_target_enable && (bus.cbe == spbs_pkg::CMD_MEM_RD || bus.cbe == spbs_pkg::CMD_MEM_WR))
          begin
            next_wr_addr = bus.ad;
            next_write_q = (bus.cbe == spbs_pkg::CMD_MEM_WR);
            next_devsel_o = 1'b0;
            next_devsel_oe = 1'b1;
            next_trdy_o = 1'b1;
            next_trdy_oe = 1'b1;
            next_tst = T_CLAIM;
          end
        end
      end
      T_CLAIM:
      begin
        // Read data waits one clock for the lanes to turn around
        next_trdy_o = 1'b0;
        next_ad_o = i_read_data;
        next_ad_oe = ~write_q;
        next_tst = T_DATA;
      end
      T_DATA:
      begin
        // target ready held until the initiator is ready
        // data moves on this clock edge
        if (!bus.secondary_initiator_ready_n)
        begin
          next_wr_valid = write_q;
          next_wr_data = bus.ad;
          next_wr_be = bus.cbe;
          // write parity one clock after the transfer
          next_chk_en = write_q;
          // drive high for one clock before release
          next_trdy_o = 1'b1;
          next_devsel_o = 1'b1;
          next_ad_oe = 1'b0;
          next_tst = T_TURN;
        end
        // Initiator gave up on us
        else if (bus.frame_n)
        begin
          next_trdy_o = 1'b1;
          next_devsel_o = 1'b1;
          next_ad_oe = 1'b0;
          next_tst = T_TURN;
        end
      end
      T_TURN:
      begin
        next_trdy_oe = 1'b0;
        next_devsel_oe = 1'b0;
        next_tst = T_IDLE;
      end
    endcase
    if (bus_rst)
    begin
      next_tst = T_IDLE;
      next_ad_oe = 1'b0;
      next_trdy_oe = 1'b0;
      next_devsel_oe = 1'b0;
      next_chk_en = 1'b0;
      next_par_err = 1'b0;
    end
  end

  always_ff @(posedge bus.pci_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      tst <= T_IDLE;
      write_q <= 1'b0;
      frame_prev <= 1'b1;
      o_wr_valid <= 1'b0;
      o_wr_addr <= 32'h0000_0000;
      o_wr_data <= 32'h0000_0000;
      o_wr_be <= 4'h0;
      o_par_err <= 1'b0;
      ad_o <= 32'h0000_0000;
      ad_oe <= 1'b0;
      par_o <= 1'b0;
      par_oe <= 1'b0;
      trdy_o <= 1'b1;
      trdy_oe <= 1'b0;
      devsel_o <= 1'b1;
      devsel_oe <= 1'b0;
      chk_en <= 1'b0;
      chk_lanes <= 36'h0_0000_0000;
      gnt_n <= 1'b1;
      m66_oe <= 1'b0;
      m66_s1 <= 1'b0;
      o_fast_capable <= 1'b0;
    end
    else
    begin
      tst <= next_tst;
      write_q <= next_write_q;
      frame_prev <= bus.frame_n;
      o_wr_valid <= next_wr_valid;
      o_wr_addr <= next_wr_addr;
      o_wr_data <= next_wr_data;
      o_wr_be <= next_wr_be;
      o_par_err <= next_par_err;
      ad_o <= next_ad_o;
      ad_oe <= next_ad_oe;
      par_o <= next_par_o;
      // parity released a clock after the lanes
      par_oe <= ad_oe;
      trdy_o <= next_trdy_o;
      trdy_oe <= next_trdy_oe;
      devsel_o <= next_devsel_o;
      devsel_oe <= next_devsel_oe;
      chk_en <= next_chk_en;
      chk_lanes <= next_chk_lanes;
      gnt_n <= ~i_grant_device;
      m66_oe <= i_slow_bus;
      m66_s1 <= bus.secondary_fast_clock_capable_line;
      o_fast_capable <= m66_s1;
    end
  end

  assign bus.far_ad = ad_o;
  assign bus.far_ad_oe = ad_oe;
  assign bus.far_par = par_o;
  assign bus.far_par_oe = par_oe;
  assign bus.far_trdy_n = trdy_o;
  assign bus.far_trdy_oe = trdy_oe;
  assign bus.far_devsel_n = devsel_o;
  assign bus.far_devsel_oe = devsel_oe;
  assign bus.far_m66_oe = m66_oe;
  assign bus.far_gnt_n = gnt_n;
endmodule : spbs_agent_end
`default_nettype wire

// ---- verif/spbs_bus_props.sv ----
/*
  Assertions on the secondary bus lines between the two ends.
  Assumes the inputs are the carrier's own signals, on the link clock.
*/
`timescale 1ns/10ps
`default_nettype none
module spbs_bus_props (
  // Link clock and reset
  input wire logic pci_clk,
  input wire logic dev_sec_rst_n,
  // Resolved lines
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic par,
  input wire logic frame_n,
  input wire logic secondary_initiator_ready_n,
  input wire logic secondary_target_ready_n,
  input wire logic secondary_device_select_n,
  // Bridge drives
  input wire logic dev_ad_oe,
  input wire logic dev_cbe_oe,
  input wire logic dev_par_oe,
  input wire logic dev_frame_n,
  input wire logic dev_frame_oe,
  input wire logic dev_irdy_n,
  input wire logic dev_irdy_oe
);
  wire irdy_n = secondary_initiator_ready_n;
  wire trdy_n = secondary_target_ready_n;
  wire dsel_n = secondary_device_select_n;
  default clocking cb @(posedge pci_clk);
  endclocking
  default disable iff (!dev_sec_rst_n);
  property p_par_even;
    dev_par_oe && $past(dev_ad_oe) && $past(dev_cbe_oe) |-> par == ^{$past(ad), $past(cbe)};
  endproperty
  a_par_even: assert property (p_par_even) else $error("parity not even");
  property p_frame_addr;
    $fell(frame_n) |-> dev_ad_oe && (cbe == spbs_pkg::CMD_MEM_RD || cbe == spbs_pkg::CMD_MEM_WR);
  endproperty
  a_frame_addr: assert property (p_frame_addr) else $error("no address or command at frame");
  property p_frame_one;
    $fell(frame_n) |=> frame_n && !irdy_n;
  endproperty
  a_frame_one: assert property (p_frame_one) else $error("frame not ended in data phase");
  property p_irdy_hold;
    $rose(irdy_n) |-> $past(!trdy_n) || $past(dsel_n);
  endproperty
  a_irdy_hold: assert property (p_irdy_hold) else $error("ready dropped early");
  property p_frame_turn;
    $fell(dev_frame_oe) |-> $past(dev_frame_n);
  endproperty
  a_frame_turn: assert property (p_frame_turn) else $error("frame released while low");
  property p_irdy_turn;
    $fell(dev_irdy_oe) |-> $past(dev_irdy_n) && !$past(dev_irdy_n, 2);
  endproperty
  a_irdy_turn: assert property (p_irdy_turn) else $error("ready not high before release");
  property p_par_release;
    $fell(dev_ad_oe) |-> dev_par_oe ##1 !dev_par_oe;
  endproperty
  a_par_release: assert property (p_par_release) else $error("parity release timing");
  property p_abort;
    $fell(frame_n) ##1 dsel_n [*4] |-> !irdy_n ##1 irdy_n;
  endproperty
  a_abort: assert property (p_abort) else $error("abort timing");
  c_xfer: cover property (!irdy_n && !trdy_n);
  c_abort: cover property ($fell(frame_n) ##1 dsel_n [*4]);
  c_park: cover property (dev_ad_oe && frame_n && irdy_n && !dev_frame_oe);
endmodule : spbs_bus_props
`default_nettype wire

// ---- verif/secondary_pci_bus_signalling_tb.sv ----
/*
  Bench joining both ends; scenarios drive the user and agent sides.
  Assumes the design files and the package are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module secondary_pci_bus_signalling_tb;
  logic i_ref_clk = 0, lk = 0, i_sys_rst = 1, v = 0, wr = 0, sy = 0, p66 = 1, cfg = 1, sbr = 0;
  logic gnt = 0, ten = 0, fq = 1, rdy, rv, rab, wv, perr, fcap;
  logic [31:0] addr = 0, data = 0, rdat = 0, rd, st, wa, wd, m_ad, s_wa, s_wd;
  logic [3:0] be = 0, wb, m_cbe, s_wb;
  int fails = 0, comparisons = 0, cyc = 0, perrs = 0, wcnt = 0;
  initial forever #50 i_ref_clk = ~i_ref_clk;
  initial
  begin
    #5;
    forever #24 lk = ~lk;
  end
  spbs_bus_if bus (.pci_clk(lk));
  spbs_bridge_end i_spbs_bridge_end (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_req_valid(v),
    .i_req_write(wr), .i_req_addr(addr), .i_req_data(data), .i_req_be(be), .o_req_ready(rdy),
    .o_rsp_valid(rv), .o_rsp_data(rd), .o_rsp_abort(rab), .i_sync_mode(sy),
    .i_primary_fast_clock_capable_in(p66), .i_fast_clock_config_strap(cfg),
    .i_sec_bus_reset(sbr), .o_status_word(st), .bus(bus));
  spbs_agent_end i_spbs_agent_end (.i_sys_rst(i_sys_rst), .i_grant_device(gnt), .i_target_enable(ten),
    .i_slow_bus(1'b0), .i_read_data(rdat), .o_wr_valid(wv), .o_wr_addr(wa), .o_wr_data(wd),
    .o_wr_be(wb), .o_par_err(perr), .o_fast_capable(fcap), .bus(bus));
  spbs_bus_props i_spbs_bus_props (.pci_clk(lk), .dev_sec_rst_n(bus.dev_sec_rst_n), .ad(bus.ad),
    .cbe(bus.cbe), .par(bus.par), .frame_n(bus.frame_n),
    .secondary_initiator_ready_n(bus.secondary_initiator_ready_n),
    .secondary_target_ready_n(bus.secondary_target_ready_n),
    .secondary_device_select_n(bus.secondary_device_select_n), .dev_ad_oe(bus.dev_ad_oe),
    .dev_cbe_oe(bus.dev_cbe_oe), .dev_par_oe(bus.dev_par_oe), .dev_frame_n(bus.dev_frame_n),
    .dev_frame_oe(bus.dev_frame_oe), .dev_irdy_n(bus.dev_irdy_n), .dev_irdy_oe(bus.dev_irdy_oe));
  // Record the address phase and each write the agent accepts
  always @(posedge lk)
  begin
    fq <= bus.frame_n;
    if (fq && !bus.frame_n)
    begin
      m_ad <= bus.ad;
      m_cbe <= bus.cbe;
    end
    if (wv)
    begin
      s_wa <= wa;
      s_wd <= wd;
      s_wb <= wb;
      wcnt++;
    end
    if (perr)
      perrs++;
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      wrap_up;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic chb(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask : chb
  task automatic wt(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : wt
  // One word through the bridge; waits a bounded time for the answer
  task automatic req(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] e);
    int n;
    wt(1);
    v = 1;
    wr = w;
    addr = a;
    data = d;
    be = e;
    do @(posedge i_ref_clk); while (rdy !== 1'b1);
    #1 v = 0;
    for (n = 0; n < 300 && rv !== 1'b1; n++)
      wt(1);
    chb("answer", 1, rv);
  endtask : req
  task automatic rst_chk;
    chk("reset ad", 0, bus.ad);
    chk("reset cbe", 0, {28'h0, bus.cbe});
    chb("reset par", 0, bus.par);
    chb("reset frame oe", 0, bus.dev_frame_oe);
  endtask : rst_chk
  task automatic t_park;
    gnt = 1;
    wt(10);
    chb("park ad oe", 1, bus.dev_ad_oe);
    chb("park par oe", 1, bus.dev_par_oe);
    chb("park par", ^{bus.ad, bus.cbe}, bus.par);
    gnt = 0;
    wt(6);
    chb("unpark par oe", 0, bus.dev_par_oe);
    gnt = 1;
  endtask : t_park
  task automatic t_write;
    int i;
    ten = 1;
    for (i = 0; i < 2; i++)
    begin
      req(1, 32'h0000_1004 + i, 32'ha5c3_0f01 ^ i, i ? 4'ha : 4'h0);
      chk("addr", 32'h0000_1004 + i, m_ad);
      chk("waddr", 32'h0000_1004 + i, s_wa);
      chk("cmd", spbs_pkg::CMD_MEM_WR, {28'h0, m_cbe});
      chk("wdata", 32'ha5c3_0f01 ^ i, s_wd);
      chk("wbe", i ? 4'ha : 4'h0, {28'h0, s_wb});
      chb("abort", 0, rab);
    end
    chk("writes", 2, wcnt);
  endtask : t_write
  task automatic t_read;
    rdat = 32'h5e1f_9a37;
    req(0, 32'h0000_2008, 0, 4'h0);
    chk("cmd", spbs_pkg::CMD_MEM_RD, {28'h0, m_cbe});
    chk("rdata", 32'h5e1f_9a37, rd);
    chk("parity errors", 0, perrs);
  endtask : t_read
  task automatic t_abort;
    ten = 0;
    req(1, 32'h0000_3000, 32'h1, 4'h0);
    chb("abort", 1, rab);
    chk("abort data", 32'hffff_ffff, rd);
    chk("parity errors", 0, perrs);
    chk("writes", 2, wcnt);
  endtask : t_abort
  task automatic t_m66;
    sy = 1;
    p66 = 0;
    wt(10);
    chb("m66 line", 0, bus.secondary_fast_clock_capable_line);
    chb("fast capable", 0, fcap);
    chb("status 21", cfg, st[spbs_pkg::STATUS_FAST_BIT]);
    sy = 0;
    wt(10);
    chb("m66 line", 1, bus.secondary_fast_clock_capable_line);
    chb("fast capable", 1, fcap);
    chb("status 21", 0, st[spbs_pkg::STATUS_FAST_BIT]);
    p66 = 1;
    wt(10);
    chb("status 21", 1, st[spbs_pkg::STATUS_FAST_BIT]);
  endtask : t_m66
  initial
  begin
    wt(3);
    rst_chk;
    wt(3);
    i_sys_rst = 0;
    wt(4);
    t_park;
    t_write;
    t_read;
    t_abort;
    t_m66;
    sbr = 1;
    wt(10);
    rst_chk;
    sbr = 0;
    wt(10);
    wrap_up;
  end
endmodule : secondary_pci_bus_signalling_tb
`default_nettype wire
